//--- sacp_defs.svh
// constants for the converter control block: bit positions, reset values,
// widths and timing counts; included by the package and the design file
`ifndef SACP_DEFS_SVH
`define SACP_DEFS_SVH

`define SACP_CLK_MHZ        200
`define SACP_REF_SETUP_US   1
`define SACP_REF_SETUP_CYC  (`SACP_REF_SETUP_US * `SACP_CLK_MHZ)
`define SACP_RES_BITS       10
`define SACP_MSB            4'h9
`define SACP_MSB_TRIAL      10'h200
`define SACP_PAD_BITS       6
`define SACP_CTRL_RESET     8'h00
`define SACP_CHSEL_RESET    8'h00
`define SACP_PFM_RESET      8'h00
`define SACP_PFT_RESET      8'h00
`define SACP_CTRL_CONV_EN   7
`define SACP_CTRL_MODE      6
`define SACP_CTRL_TSEL_HI   5
`define SACP_CTRL_TSEL_LO   1
`define SACP_CTRL_REF_EN    0
`define SACP_CHSEL_LO       0
`define SACP_CHSEL_HI       1
`define SACP_PFM_ENABLE     7
`define SACP_PFM_POLARITY   6
`define SACP_SAMPLE_CYC     8'h10
`define SACP_STEP_CYC       8'h04

`endif

//--- sacp_pkg.sv
// types shared by the converter control block
// assumes sacp_defs.svh is on the include path
`include "sacp_defs.svh"

package sacp_pkg;

  typedef enum logic [3:0] {
    SACP_IDLE   = 4'b0001,
    SACP_SAMPLE = 4'b0010,
    SACP_STEP   = 4'b0100,
    SACP_DONE   = 4'b1000
  } sacp_state_e;

  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  chSel;
    logic [7:0]  pfMode;
    logic [7:0]  pfThresh;
    logic [15:0] result;
    logic [9:0]  approx;
    logic [3:0]  bitIdx;
    logic [7:0]  timer;
    logic [7:0]  refCount;
    logic        refOn;
    logic        refReady;
    sacp_state_e state;
    logic        irq;
    logic        waitReq;
    logic [3:0]  digitalMask;
    logic [3:0]  chanOneHot;
    logic        sampleHold;
    logic [9:0]  dacCode;
    logic [2:0]  cmpSync;
    logic        cmpFilt;
  } sacp_state_s;

endpackage : sacp_pkg

//--- sacp_adc_control.sv
// control logic of a four-channel 10-bit successive approximation converter
// assumes a simple cpu register port on the same clock and an analog front
// end (sample/hold, resistor string, comparator) driven from these outputs
//
// Functional notes
// - repeat conversions on selected channel while enabled
// - interrupt on every conversion, comparison off
// - with comparison on, interrupt only on match
// - unselected analog pins stay digital inputs
// - resolve approximation msb first, one bit/step
// - copy approximation into result after lsb
// - result in upper ten bits, low six zero
// - reset clears control register to zero
// - decode enable pair into four modes
// - 00 to 10 starts reference, clear stops it
// - 00 to 11 starts reference, clear keeps it
// - reference set-up at least 1 us
// - control register write inserts wait cycle
// - four channels, ten-bit results
// - compare enable: 0 normal, 1 power-fail
// - polarity 0 at-or-above, 1 below threshold
// - threshold against upper eight result bits
`timescale 1ns/1ps
`default_nettype none
`include "sacp_defs.svh"

module sacp_adc_control (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        ctrlWrite,
  input  wire logic [7:0]  ctrlWdata,
  input  wire logic        chSelWrite,
  input  wire logic [7:0]  chSelWdata,
  input  wire logic        pfModeWrite,
  input  wire logic [7:0]  pfModeWdata,
  input  wire logic        pfThreshWrite,
  input  wire logic [7:0]  pfThreshWdata,
  input  wire logic        compareIn,
  output logic [7:0]  ctrlRdata,
  output logic [7:0]  chSelRdata,
  output logic [7:0]  pfModeRdata,
  output logic [7:0]  pfThreshRdata,
  output logic [15:0] resultRdata,
  output logic        busWait,
  output logic        conversionDoneIrq,
  output logic        refBoostOn,
  output logic        refReady,
  output logic        sampleHold,
  output logic [3:0]  channelSelect,
  output logic [3:0]  digitalInputEnable,
  output logic [9:0]  dacCode
);

  sacp_pkg::sacp_state_s s_q;
  sacp_pkg::sacp_state_s s_d;

  function automatic logic [3:0] chanDecode(input logic [7:0] sel);
    chanDecode = 4'h1 << sel[`SACP_CHSEL_HI:`SACP_CHSEL_LO];
  endfunction : chanDecode

  function automatic logic pfMatch(input logic [9:0] res,
                                   input logic [7:0] thr,
                                   input logic       below);
    pfMatch = below ? (res[9:2] < thr) : (res[9:2] >= thr);
  endfunction : pfMatch

  logic convEn;
  logic refEn;
  logic cmpBit;
  logic pfOn;
  logic pfBelow;
  logic [7:0] setupCyc;

  assign convEn   = s_q.ctrl[`SACP_CTRL_CONV_EN];
  assign refEn    = s_q.ctrl[`SACP_CTRL_REF_EN];
  assign cmpBit   = s_q.cmpFilt;
  assign pfOn     = s_q.pfMode[`SACP_PFM_ENABLE];
  assign pfBelow  = s_q.pfMode[`SACP_PFM_POLARITY];
  assign setupCyc = 8'(`SACP_REF_SETUP_CYC);

  always_comb
  begin
    s_d         = s_q;
    s_d.irq     = 1'b0;
    s_d.waitReq = 1'b0;
    // comparator crosses from the analog domain
    s_d.cmpSync = {s_q.cmpSync[1:0], compareIn};
    // level accepted once last two stages agree
    if (s_q.cmpSync[2] == s_q.cmpSync[1])
      s_d.cmpFilt = s_q.cmpSync[2];

    if (ctrlWrite)
    begin
      s_d.ctrl    = ctrlWdata;
      s_d.waitReq = 1'b1;
    end
    if (chSelWrite)
    begin
      s_d.chSel   = chSelWdata;
      s_d.waitReq = 1'b1;
    end
    if (pfModeWrite)
    begin
      s_d.pfMode  = {pfModeWdata[`SACP_PFM_ENABLE:`SACP_PFM_POLARITY],
                     {`SACP_PFM_POLARITY{1'b0}}};
      s_d.waitReq = 1'b1;
    end
    if (pfThreshWrite)
    begin
      s_d.pfThresh = pfThreshWdata;
      s_d.waitReq  = 1'b1;
    end

    // reference on while either enable bit set
    // auto on with conversion, off when cleared
    // stays on while reference enable held
    s_d.refOn = s_d.ctrl[`SACP_CTRL_CONV_EN] | s_d.ctrl[`SACP_CTRL_REF_EN];
    if (!s_q.refOn)
    begin
      s_d.refCount = 8'h00;
      s_d.refReady = 1'b0;
    end
    else if (s_q.refCount != setupCyc)
      s_d.refCount = s_q.refCount + 8'h01;
    else
      s_d.refReady = 1'b1;

    s_d.chanOneHot  = chanDecode(s_q.chSel);
    s_d.digitalMask = ~chanDecode(s_q.chSel);

    case (s_q.state)
      sacp_pkg::SACP_IDLE:
      begin
        s_d.sampleHold = 1'b0;
        if (convEn)
        begin
          s_d.state = sacp_pkg::SACP_SAMPLE;
          s_d.timer = `SACP_SAMPLE_CYC;
        end
      end
      sacp_pkg::SACP_SAMPLE:
      begin
        s_d.sampleHold = 1'b0;
        if (s_q.timer != 8'h00)
          s_d.timer = s_q.timer - 8'h01;
        else
        begin
          s_d.sampleHold = 1'b1;
          s_d.bitIdx  = `SACP_MSB;
          s_d.approx  = `SACP_MSB_TRIAL;
          s_d.dacCode = `SACP_MSB_TRIAL;
          s_d.timer   = `SACP_STEP_CYC;
          s_d.state   = sacp_pkg::SACP_STEP;
        end
      end
      sacp_pkg::SACP_STEP:
      begin
        if (s_q.timer != 8'h00)
          s_d.timer = s_q.timer - 8'h01;
        else
        begin
          // keep or drop trial bit, move to next
          s_d.approx[s_q.bitIdx] = cmpBit;
          if (s_q.bitIdx == 4'h0)
            s_d.state = sacp_pkg::SACP_DONE;
          else
          begin
            s_d.bitIdx = s_q.bitIdx - 4'h1;
            s_d.approx[s_q.bitIdx - 4'h1] = 1'b1;
            s_d.timer  = `SACP_STEP_CYC;
          end
          s_d.dacCode = s_d.approx;
        end
      end
      sacp_pkg::SACP_DONE:
      begin
        s_d.sampleHold = 1'b0;
        s_d.result = {s_q.approx, {`SACP_PAD_BITS{1'b0}}};
        s_d.irq = pfOn ? pfMatch(s_q.approx, s_q.pfThresh, pfBelow) : 1'b1;
        if (convEn)
        begin
          s_d.state = sacp_pkg::SACP_SAMPLE;
          s_d.timer = `SACP_SAMPLE_CYC;
        end
        else
          s_d.state = sacp_pkg::SACP_IDLE;
      end
      default:
        s_d.state = sacp_pkg::SACP_IDLE;
    endcase

    // clearing enable aborts a conversion in flight
    if (!convEn && s_q.state != sacp_pkg::SACP_DONE)
    begin
      s_d.state      = sacp_pkg::SACP_IDLE;
      s_d.sampleHold = 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      s_q             <= '0;
      s_q.ctrl        <= `SACP_CTRL_RESET;
      s_q.chSel       <= `SACP_CHSEL_RESET;
      s_q.pfMode      <= `SACP_PFM_RESET;
      s_q.pfThresh    <= `SACP_PFT_RESET;
      s_q.state       <= sacp_pkg::SACP_IDLE;
      s_q.digitalMask <= 4'hf;
    end
    else
      s_q <= s_d;
  end

  assign ctrlRdata          = s_q.ctrl;
  assign chSelRdata         = s_q.chSel;
  assign pfModeRdata        = s_q.pfMode;
  assign pfThreshRdata      = s_q.pfThresh;
  assign resultRdata        = s_q.result;
  assign busWait            = s_q.waitReq;
  assign conversionDoneIrq  = s_q.irq;
  assign refBoostOn         = s_q.refOn;
  assign refReady           = s_q.refReady;
  assign sampleHold         = s_q.sampleHold;
  assign channelSelect      = s_q.chanOneHot;
  assign digitalInputEnable = s_q.digitalMask;
  assign dacCode            = s_q.dacCode;

endmodule : sacp_adc_control
`default_nettype wire

//--- sacp_adc_control_properties.sv
// port checks for the converter control block
// assumes it is bound onto sacp_adc_control
`timescale 1ns/1ps
`default_nettype none
module sacp_adc_control_properties (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        ctrlWrite,
  input wire logic [7:0]  ctrlWdata,
  input wire logic [7:0]  ctrlRdata,
  input wire logic [7:0]  pfModeRdata,
  input wire logic [7:0]  pfThreshRdata,
  input wire logic [15:0] resultRdata,
  input wire logic        conversionDoneIrq,
  input wire logic        refBoostOn,
  input wire logic        sampleHold,
  input wire logic [3:0]  channelSelect,
  input wire logic [3:0]  digitalInputEnable,
  input wire logic [9:0]  dacCode
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  property p_lowZero; resultRdata[5:0] == 6'h00; endproperty
  a_lowZero: assert property (p_lowZero) else $error("low bits");
  property p_irqPulse;
    conversionDoneIrq |=> !conversionDoneIrq [*8];
  endproperty
  a_irqPulse: assert property (p_irqPulse) else $error("irq width");
  property p_above;
    conversionDoneIrq && pfModeRdata[7:6] == 2'b10 |->
      resultRdata[15:8] >= pfThreshRdata;
  endproperty
  a_above: assert property (p_above) else $error("irq not above");
  property p_below;
    conversionDoneIrq && pfModeRdata[7:6] == 2'b11 |->
      resultRdata[15:8] < pfThreshRdata;
  endproperty
  a_below: assert property (p_below) else $error("irq not below");
  property p_ctrlWr; ctrlWrite |=> ctrlRdata == $past(ctrlWdata); endproperty
  a_ctrlWr: assert property (p_ctrlWr) else $error("ctrl write");
  property p_ref; refBoostOn == (ctrlRdata[7] | ctrlRdata[0]); endproperty
  a_ref: assert property (p_ref) else $error("boost level");
  property p_digital; digitalInputEnable == ~channelSelect; endproperty
  a_digital: assert property (p_digital) else $error("digital pins");
  property p_msb; $rose(sampleHold) |-> dacCode == 10'h200; endproperty
  a_msb: assert property (p_msb) else $error("first trial");
  c_irq: cover property (conversionDoneIrq);
  c_hold: cover property ($rose(sampleHold));
  c_pf: cover property (conversionDoneIrq && pfModeRdata[7]);
endmodule : sacp_adc_control_properties
bind sacp_adc_control sacp_adc_control_properties u_props (
  .clock, .reset, .ctrlWrite, .ctrlWdata, .ctrlRdata, .pfModeRdata,
  .pfThreshRdata, .resultRdata, .conversionDoneIrq, .refBoostOn,
  .sampleHold, .channelSelect, .digitalInputEnable, .dacCode
);
`default_nettype wire

//--- sacp_analog_model.sv
// comparator stand-in for the analog front end
// assumes vin is held steady by the bench
`timescale 1ns/1ps
`default_nettype none
module sacp_analog_model (
  input  wire logic       clock,
  input  wire logic       sampleHold,
  input  wire logic [9:0] dacCode,
  input  wire logic [9:0] vin,
  output logic            compareIn
);
  logic toggle = 1'b0;
  always @(posedge clock) toggle <= ~toggle;
  assign compareIn = sampleHold ? (vin >= dacCode) : toggle;
endmodule : sacp_analog_model
`default_nettype wire

//--- sacp_adc_control_tb.sv
// self-checking bench for the converter control block
// assumes the analog model and checker compile first
`timescale 1ns/1ps
`default_nettype none
module sacp_adc_control_tb;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  we = 4'h0;
  logic [7:0]  wd = 8'h00;
  logic [9:0]  vin = 10'h2a5;
  logic        seen;
  logic [7:0]  ctrlRdata, chSelRdata, pfModeRdata, pfThreshRdata;
  logic [15:0] resultRdata;
  logic        busWait, irq, refBoostOn, refReady, sampleHold, compareIn;
  logic [3:0]  channelSelect, digitalInputEnable;
  logic [9:0]  dacCode;
  int          fails = 0;
  int          testsRun = 0;
  logic [8:0]  refSeq [5] = '{9'h101, 9'h000, 9'h103, 9'h003, 9'h000};
  logic [16:0] pfSeq [4] = '{{8'h80, 8'h55, 1'b1}, {8'h80, 8'h56, 1'b0},
                             {8'hc0, 8'h56, 1'b1}, {8'hc0, 8'h55, 1'b0}};
  sacp_adc_control dut (
    .clock, .reset, .compareIn, .ctrlWrite(we[0]), .ctrlWdata(wd),
    .chSelWrite(we[1]), .chSelWdata(wd), .pfModeWrite(we[2]),
    .pfModeWdata(wd), .pfThreshWrite(we[3]), .pfThreshWdata(wd),
    .ctrlRdata, .chSelRdata, .pfModeRdata, .pfThreshRdata, .resultRdata,
    .busWait, .conversionDoneIrq(irq), .refBoostOn, .refReady, .sampleHold,
    .channelSelect, .digitalInputEnable, .dacCode
  );
  sacp_analog_model u_front (.clock, .sampleHold, .dacCode, .vin, .compareIn);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input int s, input logic [7:0] d);
    @(negedge clock);
    we[s] = 1'b1;
    wd = d;
    @(negedge clock);
    we = 4'h0;
  endtask : wr
  task automatic waitIrq;
    seen = 1'b0;
    repeat (200)
    begin
      @(posedge clock);
      #1;
      if (irq === 1'b1)
        seen = 1'b1;
    end
  endtask : waitIrq
  task automatic finish_test;
    if (fails == 0 && testsRun > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  initial
  begin
    forever #2.5 clock = ~clock;
  end
  initial
  begin
    #50000;
    fails++;
    finish_test();
  end
  initial
  begin
    repeat (20) @(negedge clock);
    chk(digitalInputEnable, 4'hf);
    reset = 1'b0;
    chk(ctrlRdata, 8'h00);
    wr(1, 8'h02);
    chk(busWait, 1'b1);
    chk(chSelRdata, 8'h02);
    @(negedge clock);
    chk(digitalInputEnable, 4'hb);
    chk(channelSelect, 4'h4);
    wr(2, 8'hff);
    chk(pfModeRdata, 8'hc0);
    wr(2, 8'h00);
    foreach (refSeq[i])
    begin
      wr(0, refSeq[i][8:1]);
      chk(refBoostOn, refSeq[i][0]);
    end
    wr(0, 8'h3f);
    chk(busWait, 1'b1);
    chk(refReady, 1'b0);
    repeat (205) @(negedge clock);
    chk(refReady, 1'b1);
    wr(0, 8'hbf);
    waitIrq();
    chk(seen, 1'b1);
    chk(resultRdata, {vin, 6'h00});
    @(negedge clock);
    vin = 10'h155;
    waitIrq();
    chk(resultRdata, {vin, 6'h00});
    foreach (pfSeq[i])
    begin
      wr(0, 8'h3f);
      wr(2, pfSeq[i][16:9]);
      wr(3, pfSeq[i][8:1]);
      chk(pfThreshRdata, pfSeq[i][8:1]);
      wr(0, 8'hbf);
      waitIrq();
      chk(seen, pfSeq[i][0]);
    end
    wr(0, 8'h3f);
    reset = 1'b1;
    repeat (2) @(negedge clock);
    reset = 1'b0;
    chk(ctrlRdata, 8'h00);
    chk(refBoostOn, 1'b0);
    finish_test();
  end
endmodule : sacp_adc_control_tb
`default_nettype wire
